// file: logic/tpw_pkg.sv
// Purpose: shared constants and types of the 8-bit pwm timer output stage
// Assumes: one core clock, timer tick from the prescaler on the same clock
// Notes: register offsets are byte addresses in their own address space
package tpw_pkg;
  // ==========================================================
  // register map
  localparam logic [7:0] TPW_CTRL_A_DADDR = 8'h44;
  localparam logic [7:0] TPW_CTRL_A_IOADDR = 8'h24;
  localparam logic [7:0] TPW_CTRL_A_RESET = 8'h00;
  localparam logic [7:0] TPW_CTRL_A_WMASK = 8'hF3;
  localparam int TPW_COMA_LSB = 6;
  localparam int TPW_COMB_LSB = 4;
  localparam int TPW_WGM_LSB = 0;
  // ==========================================================
  // counter values
  localparam logic [7:0] TPW_BOTTOM = 8'h00;
  localparam logic [7:0] TPW_ONE = 8'h01;
  localparam logic [7:0] TPW_MAX = 8'hFF;
  localparam logic [9:0] TPW_PC_PERIOD = 10'h1FE;
  // ==========================================================
  // modes
  typedef enum logic [2:0] {
    TPW_NORMAL = 3'b000,
    TPW_PC_FF = 3'b001,
    TPW_CTC = 3'b010,
    TPW_FAST_FF = 3'b011,
    TPW_RSV4 = 3'b100,
    TPW_PC_OCR = 3'b101,
    TPW_RSV6 = 3'b110,
    TPW_FAST_OCR = 3'b111
  } tpw_wgm_t;
  typedef enum logic [1:0] {
    TPW_COM_OFF = 2'b00,
    TPW_COM_TOG = 2'b01,
    TPW_COM_CLR = 2'b10,
    TPW_COM_SET = 2'b11
  } tpw_com_t;
endpackage

// file: logic/tpw_link_if.sv
// Purpose: carries counter state and configuration between timer modules
// Assumes: all signals on core_clk
// Notes: none
`timescale 1ns/1ps
`default_nettype none
interface tpw_link_if;
  import tpw_pkg::*;
  logic tick;
  logic wgm2;
  logic load;
  logic [7:0] load_val;
  logic [7:0] ocr_in_a;
  logic [7:0] ocr_in_b;
  logic [7:0] ctrl_a;
  logic [7:0] count;
  logic [7:0] top;
  logic [7:0] ocr_a;
  logic [7:0] ocr_b;
  logic up;
  tpw_wgm_t mode;
  logic at_top;
  logic at_bot;
  logic ovf_evt;
  modport regs (output ctrl_a);
  modport cnt (input tick, wgm2, load, load_val, ocr_in_a, ocr_in_b, ctrl_a,
    output count, top, ocr_a, ocr_b, up, mode, at_top, at_bot, ovf_evt);
  modport wave (output tick, wgm2, load, load_val, ocr_in_a, ocr_in_b,
    input ctrl_a, count, top, ocr_a, ocr_b, up, mode, at_top, at_bot, ovf_evt);
endinterface
`default_nettype wire

// file: logic/tpw_regs.sv
// Purpose: control register A with decode in data and io address space
// Assumes: single-cycle write strobe, read data one cycle after strobe
// Notes: read data is zero when no read hits
`timescale 1ns/1ps
`default_nettype none
module tpw_regs
  import tpw_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_io_space,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  tpw_link_if.regs lnk
);
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] rdata;
  } tpw_regs_st_t;
  tpw_regs_st_t s_r;
  tpw_regs_st_t s_nxt;
  logic hit;
  // ==========================================================
  // decode: same register at both offsets
  assign hit = reg_io_space ? (reg_addr == TPW_CTRL_A_IOADDR)
                            : (reg_addr == TPW_CTRL_A_DADDR);
  always_comb begin
    s_nxt = s_r;
    if (reg_wr && hit) begin
      s_nxt.ctrl = reg_wdata & TPW_CTRL_A_WMASK;
    end
    s_nxt.rdata = (reg_rd && hit) ? s_r.ctrl : 8'h00;
  end
  // state register
  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_r <= '{ctrl: TPW_CTRL_A_RESET, rdata: 8'h00};
    end else begin
      s_r <= s_nxt;
    end
  end
  assign lnk.ctrl_a = s_r.ctrl;
  assign reg_rdata = s_r.rdata;
endmodule // tpw_regs
`default_nettype wire

// file: logic/tpw_counter.sv
// Purpose: up, wrap and dual-slope count sequence with compare buffering
// Assumes: tick is a one-cycle enable from the prescaler
// Notes: a load from software wins over a tick in the same cycle
`timescale 1ns/1ps
`default_nettype none
module tpw_counter
  import tpw_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  tpw_link_if.cnt lnk
);
  typedef struct packed {
    logic [7:0] count;
    logic up;
    logic [7:0] ocr_a;
    logic [7:0] ocr_b;
  } tpw_cnt_st_t;
  tpw_cnt_st_t s_r;
  tpw_cnt_st_t s_nxt;
  tpw_wgm_t mode;
  logic pc;
  logic fast;
  logic wrap;
  logic upd;
  logic [7:0] top;
  // ==========================================================
  // mode decode and top selection
  assign mode = tpw_wgm_t'({lnk.wgm2, lnk.ctrl_a[TPW_WGM_LSB +: 2]});
  assign pc = (mode == TPW_PC_FF) || (mode == TPW_PC_OCR);
  assign fast = (mode == TPW_FAST_FF) || (mode == TPW_FAST_OCR);
  assign top = (mode == TPW_CTC) ? lnk.ocr_in_a :
               (mode == TPW_PC_OCR || mode == TPW_FAST_OCR) ? s_r.ocr_a : TPW_MAX;
  // events only on a tick: tick is an enable, never a clock
  assign wrap = lnk.tick && (s_r.count == top || s_r.count == TPW_MAX);
  assign lnk.at_top = pc ? (lnk.tick && s_r.up && s_r.count >= top) : wrap;
  assign lnk.at_bot = pc ? (lnk.tick && !s_r.up && s_r.count == TPW_BOTTOM) : wrap;
  // a turn at top from count one also lands on bottom, so small tops still flag
  assign lnk.ovf_evt = pc ? (lnk.tick && s_r.count == TPW_ONE &&
                             (!s_r.up || s_r.count >= top)) :
                       (mode == TPW_FAST_OCR) ? wrap : (lnk.tick && s_r.count == TPW_MAX);
  // compare buffer loads at top in dual slope, at bottom in fast pwm
  assign upd = pc ? lnk.at_top : (fast ? wrap : 1'b1);
  always_comb begin
    s_nxt = s_r;
    if (upd) begin
      s_nxt.ocr_a = lnk.ocr_in_a;
      s_nxt.ocr_b = lnk.ocr_in_b;
    end
    if (lnk.tick) begin
      if (!pc) begin
        s_nxt.up = 1'b1;
        s_nxt.count = wrap ? TPW_BOTTOM : s_r.count + TPW_ONE;
      end else if (lnk.at_top) begin
        // top held for this one tick, then down
        s_nxt.up = 1'b0;
        s_nxt.count = (top == TPW_BOTTOM) ? TPW_BOTTOM : s_r.count - TPW_ONE;
      end else if (!s_r.up && s_r.count == TPW_BOTTOM) begin
        s_nxt.up = 1'b1;
        s_nxt.count = (top == TPW_BOTTOM) ? TPW_BOTTOM : TPW_ONE;
      end else begin
        s_nxt.count = s_r.up ? s_r.count + TPW_ONE : s_r.count - TPW_ONE;
      end
    end
    if (lnk.load) begin
      s_nxt.count = lnk.load_val;
    end
  end
  // state register
  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_r <= '{count: TPW_BOTTOM, up: 1'b1, ocr_a: TPW_BOTTOM, ocr_b: TPW_BOTTOM};
    end else begin
      s_r <= s_nxt;
    end
  end
  assign lnk.count = s_r.count;
  assign lnk.up = s_r.up;
  assign lnk.top = top;
  assign lnk.mode = mode;
  assign lnk.ocr_a = upd ? lnk.ocr_in_a : s_r.ocr_a;
  assign lnk.ocr_b = upd ? lnk.ocr_in_b : s_r.ocr_b;
endmodule // tpw_counter
`default_nettype wire

// file: logic/tpw_pwm_out.sv
// Purpose: waveform stage of an 8-bit timer, channels a and b, pin override
// Assumes: timer_tick, compare values and port bits come from core_clk logic
// Notes: compare values pass a buffer that follows the mode's update point
// How it works
// - dual-slope top is 0xFF in mode 1, compare value a in mode 5
// - dual slope counts up to top, turns, counts down to bottom, repeats
// - count stays at top for exactly one tick before going down
// - dual slope sets the overflow flag whenever the count reaches bottom
// - dual slope with output mode 10 gives non-inverted pwm
// - dual slope with output mode 11 gives inverted pwm
// - pwm modes: channel a mode 01 toggles on match when mode bit 2 set; b never
// - waveform reaches pin only while pin direction is output
// - non-inverted: clear on up match, set on down match; inverted opposite
// - dual-slope period is 510 ticks in mode 1 at any prescale factor
// - compare bottom gives constant low, max constant high, inverted opposite
// - leaving max moves output to up-match level at top
// - up slope that misses its match gets a compensating transition
// - counter is synchronous; tick is only an enable
// - nonzero output mode overrides port data, except 01 where it cannot toggle; direction bit enables driver
// - non-pwm modes: 00 off, 01 toggle, 10 clear, 11 set on match
// - fast pwm: 10 clear match set bottom, 11 opposite, 01 toggle if bit 2
// - fast pwm with compare at top ignores match, acts at bottom
// - dual slope with compare at top ignores match, acts at top
// - control register a at 0x44 data space, 0x24 io space, resets 0x00
`timescale 1ns/1ps
`default_nettype none
module tpw_pwm_out
  import tpw_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic timer_tick,
  input wire logic waveform_mode_bit2,
  input wire logic [7:0] compare_value_a,
  input wire logic [7:0] compare_value_b,
  input wire logic count_load,
  input wire logic [7:0] count_wdata,
  input wire logic [7:0] reg_addr,
  input wire logic reg_io_space,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic port_data_a,
  input wire logic port_dir_a,
  input wire logic port_data_b,
  input wire logic port_dir_b,
  output logic wave_out_a,
  output logic wave_out_b,
  output logic pin_a_out,
  output logic pin_a_oe,
  output logic pin_b_out,
  output logic pin_b_oe,
  output logic [7:0] count_value,
  input wire logic overflow_clear,
  output logic overflow_flag
);
  // ==========================================================
  // state
  typedef struct packed {
    logic [1:0] wave;
    logic [1:0] upm;
    logic ovf;
    logic armed;
    logic [9:0] per;
  } tpw_wave_st_t;
  tpw_wave_st_t s_r;
  tpw_wave_st_t s_nxt;
  tpw_link_if lnk();
  tpw_com_t com_c [2];
  logic [7:0] ocr_c [2];
  logic match_c [2];
  logic tog_ok [2];
  logic conn [2];
  logic pc;
  logic fast;
  logic pwm;

  // ==========================================================
  // submodules
  tpw_regs u_regs (
    .core_clk(core_clk),
    .rst(rst),
    .reg_addr(reg_addr),
    .reg_io_space(reg_io_space),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .lnk(lnk.regs)
  );
  tpw_counter u_cnt (
    .core_clk(core_clk),
    .rst(rst),
    .lnk(lnk.cnt)
  );

  // inputs toward the counter, all from core_clk logic
  assign lnk.tick = timer_tick;
  assign lnk.wgm2 = waveform_mode_bit2;
  assign lnk.load = count_load;
  assign lnk.load_val = count_wdata;
  assign lnk.ocr_in_a = compare_value_a;
  assign lnk.ocr_in_b = compare_value_b;

  // ==========================================================
  // mode and per-channel decode
  assign pc = (lnk.mode == TPW_PC_FF) || (lnk.mode == TPW_PC_OCR);
  assign fast = (lnk.mode == TPW_FAST_FF) || (lnk.mode == TPW_FAST_OCR);
  assign pwm = pc || fast;
  assign com_c[0] = tpw_com_t'(lnk.ctrl_a[TPW_COMA_LSB +: 2]);
  assign com_c[1] = tpw_com_t'(lnk.ctrl_a[TPW_COMB_LSB +: 2]);
  assign ocr_c[0] = lnk.ocr_a;
  assign ocr_c[1] = lnk.ocr_b;

  // one loop per channel; only channel a may toggle in pwm modes
  for (genvar c = 0; c < 2; c++) begin : g_ch
    assign match_c[c] = lnk.tick && (lnk.count == ocr_c[c]);
    assign tog_ok[c] = !pwm || ((c == 0) && lnk.wgm2);
    assign conn[c] = (com_c[c] != TPW_COM_OFF) &&
                     ((com_c[c] != TPW_COM_TOG) || tog_ok[c]);
  end

  // ==========================================================
  // waveform next state
  always_comb begin
    s_nxt = s_r;
    for (int c = 0; c < 2; c++) begin
      if (pc && lnk.at_bot) begin
        s_nxt.upm[c] = 1'b0;
      end
      case (com_c[c])
        TPW_COM_OFF: begin
          s_nxt.wave[c] = s_r.wave[c];
        end
        TPW_COM_TOG: begin
          if (tog_ok[c] && match_c[c]) begin
            s_nxt.wave[c] = ~s_r.wave[c];
          end
        end
        TPW_COM_CLR, TPW_COM_SET: begin
          if (!pwm) begin
            if (match_c[c]) begin
              s_nxt.wave[c] = com_c[c][0];
            end
          end else if (fast) begin
            // compare at top: match ignored, bottom action alone
            if (match_c[c] && ocr_c[c] != lnk.top) begin
              s_nxt.wave[c] = com_c[c][0];
            end
            if (lnk.at_bot) begin
              s_nxt.wave[c] = ~com_c[c][0];
            end
          end else if (lnk.at_top) begin
            if (ocr_c[c] == lnk.top) begin
              s_nxt.wave[c] = ~com_c[c][0];
            end else if (!s_r.upm[c]) begin
              // no up match this slope: land on the up-match level
              s_nxt.wave[c] = com_c[c][0];
            end
          end else if (match_c[c]) begin
            // bottom counts as up slope so compare zero stays low
            if (lnk.up || lnk.count == TPW_BOTTOM) begin
              s_nxt.wave[c] = com_c[c][0];
              s_nxt.upm[c] = 1'b1;
            end else begin
              s_nxt.wave[c] = ~com_c[c][0];
            end
          end
        end
        default: begin
          s_nxt.wave[c] = s_r.wave[c];
        end
      endcase
    end
    // sticky overflow: a set in the clearing cycle wins
    s_nxt.ovf = lnk.ovf_evt || (s_r.ovf && !overflow_clear);
    // period watch for the fixed-top dual slope, read only by checks
    if (lnk.ovf_evt) begin
      s_nxt.per = 10'h001;
      s_nxt.armed = 1'b1;
    end else if (lnk.tick) begin
      s_nxt.per = s_r.per + 10'h001;
    end
    if (lnk.load || lnk.mode != TPW_PC_FF) begin
      s_nxt.armed = 1'b0;
    end
  end

  // state register
  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_r <= '{wave: 2'b00, upm: 2'b00, ovf: 1'b0, armed: 1'b0, per: 10'h000};
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // outputs and pin override
  assign wave_out_a = s_r.wave[0];
  assign wave_out_b = s_r.wave[1];
  assign overflow_flag = s_r.ovf;
  assign count_value = lnk.count;
  // a disconnected waveform leaves the pin to port data
  assign pin_a_out = conn[0] ? s_r.wave[0] : port_data_a;
  assign pin_b_out = conn[1] ? s_r.wave[1] : port_data_b;
  // driver follows the direction bit only
  assign pin_a_oe = port_dir_a;
  assign pin_b_oe = port_dir_b;

  // ==========================================================
  // checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  sequence s_ctrl_wr;
    reg_wr && !reg_io_space && reg_addr == TPW_CTRL_A_DADDR;
  endsequence
  sequence s_ctrl_rd_io;
    reg_rd && !reg_wr && reg_io_space && reg_addr == TPW_CTRL_A_IOADDR;
  endsequence
  sequence s_pc_top_turn;
    pc && lnk.at_top && !count_load && lnk.top != TPW_BOTTOM;
  endsequence

  property p_top_ff;
    (lnk.mode == TPW_PC_FF && lnk.at_top && lnk.up) |-> lnk.count == TPW_MAX;
  endproperty
  a_top_ff: assert property (p_top_ff)
    else $error("fixed top is not 0xff");

  property p_top_hold;
    s_pc_top_turn |=> !lnk.up && count_value == $past(count_value) - TPW_ONE;
  endproperty
  a_top_hold: assert property (p_top_hold)
    else $error("count did not turn down after one tick at top");

  property p_bot_turn;
    (pc && timer_tick && !lnk.up && lnk.count == TPW_BOTTOM && !count_load &&
     lnk.top != TPW_BOTTOM) |=> lnk.up && count_value == TPW_ONE;
  endproperty
  a_bot_turn: assert property (p_bot_turn)
    else $error("count did not turn up at bottom");

  property p_ovf_bottom;
    (pc && timer_tick && !lnk.up && lnk.count == TPW_ONE && !count_load)
      |=> count_value == TPW_BOTTOM && overflow_flag;
  endproperty
  a_ovf_bottom: assert property (p_ovf_bottom)
    else $error("overflow not set on reaching bottom");

  property p_pc_noninv;
    (pc && com_c[0] == TPW_COM_CLR && match_c[0] && lnk.up && !lnk.at_top)
      |=> !wave_out_a;
  endproperty
  a_pc_noninv: assert property (p_pc_noninv)
    else $error("non-inverted up match did not clear");

  property p_pc_inv;
    (pc && com_c[0] == TPW_COM_SET && match_c[0] && !lnk.up &&
     lnk.count != TPW_BOTTOM) |=> !wave_out_a;
  endproperty
  a_pc_inv: assert property (p_pc_inv)
    else $error("inverted down match did not clear");

  property p_toggle;
    (lnk.wgm2 && com_c[0] == TPW_COM_TOG && match_c[0])
      |=> wave_out_a != $past(wave_out_a);
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("channel a did not toggle on match");

  property p_no_toggle_b;
    (pwm && com_c[1] == TPW_COM_TOG) |=> $stable(wave_out_b) && pin_b_out == port_data_b;
  endproperty
  a_no_toggle_b: assert property (p_no_toggle_b)
    else $error("channel b toggled in a pwm mode");

  property p_pin;
    (com_c[0] == TPW_COM_CLR) |-> pin_a_out == wave_out_a && pin_a_oe == port_dir_a;
  endproperty
  a_pin: assert property (p_pin)
    else $error("pin a does not carry the waveform");

  property p_period;
    (s_r.armed && lnk.ovf_evt) |-> s_r.per == TPW_PC_PERIOD;
  endproperty
  a_period: assert property (p_period)
    else $error("dual-slope period is not 510 ticks");

  property p_pc_top_case;
    (pc && lnk.at_top && com_c[0][1] && lnk.ocr_a == lnk.top)
      |=> wave_out_a == ~com_c[0][0];
  endproperty
  a_pc_top_case: assert property (p_pc_top_case)
    else $error("compare at top not handled at top");

  property p_miss;
    (pc && lnk.at_top && com_c[0] == TPW_COM_CLR && lnk.ocr_a != lnk.top && !s_r.upm[0])
      |=> !wave_out_a;
  endproperty
  a_miss: assert property (p_miss)
    else $error("missing compensating transition");

  property p_fast_top;
    (fast && lnk.at_bot && com_c[0][1] && lnk.ocr_a == lnk.top)
      |=> wave_out_a == ~com_c[0][0];
  endproperty
  a_fast_top: assert property (p_fast_top)
    else $error("fast pwm compare at top not done at bottom");

  property p_nonpwm;
    (!pwm && com_c[0] == TPW_COM_SET && match_c[0]) |=> wave_out_a;
  endproperty
  a_nonpwm: assert property (p_nonpwm)
    else $error("set on match failed in non-pwm mode");

  property p_reg;
    s_ctrl_wr ##1 s_ctrl_rd_io |=> reg_rdata == ($past(reg_wdata, 2) & TPW_CTRL_A_WMASK);
  endproperty
  a_reg: assert property (p_reg)
    else $error("control register a read back wrong");

  property p_ovf_hold;
    (overflow_flag && !overflow_clear) |=> overflow_flag;
  endproperty
  a_ovf_hold: assert property (p_ovf_hold)
    else $error("overflow flag dropped without clear");
endmodule // tpw_pwm_out
`default_nettype wire

// file: dv/tpw_pin_load.sv
// Purpose: port pin with an external load, as seen by the timer output stage
// Assumes: no pull resistor on the pin
// Notes: a released pin shows the inverse of its last driven level
`timescale 1ns/1ps
`default_nettype none
module tpw_pin_load (
  input wire logic core_clk,
  input wire logic pin_out,
  input wire logic pin_oe,
  output logic pin_level
);
  // ==========================================
  // last driven level, kept while released
  logic last_r = 1'b0;
  always @(posedge core_clk) begin
    if (pin_oe) begin
      last_r <= pin_out;
    end
  end
  // floating pin must not look like a valid level
  assign pin_level = pin_oe ? pin_out : ~last_r;
endmodule // tpw_pin_load
`default_nettype wire

// file: dv/timer8_phase_correct_pwm_out_bench.sv
// Purpose: self-checking bench of the 8-bit pwm timer output stage
// Assumes: tick held high, so one tick per core clock
// Notes: every case restarts the timer from reset and settles two periods
`timescale 1ns/1ps
`default_nettype none
module timer8_phase_correct_pwm_out_bench;
  import tpw_pkg::*;
  // ==========================================
  // stimulus and observed signals
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic timer_tick = 1'b1;
  logic waveform_mode_bit2 = 1'b0;
  logic [7:0] compare_value_a = 8'h00;
  logic [7:0] reg_addr = 8'h00;
  logic reg_io_space = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic port_data_a = 1'b0;
  logic port_dir_a = 1'b1;
  logic port_data_b = 1'b1;
  logic port_dir_b = 1'b1;
  logic wave_out_b, pin_b_out, pin_b_oe;
  logic overflow_clear = 1'b0;
  logic [7:0] reg_rdata;
  logic [7:0] count_value;
  logic wave_out_a, pin_a_out, pin_a_oe, overflow_flag, pin_level;
  int errors = 0;
  int n_compared = 0;
  int cyc = 0;
  // all cases together take about 25000 cycles
  localparam int CEIL = 60000;
  always #2 core_clk = ~core_clk;
  tpw_pwm_out dut_u (.core_clk(core_clk), .rst(rst), .timer_tick(timer_tick),
    .waveform_mode_bit2(waveform_mode_bit2), .compare_value_a(compare_value_a),
    .compare_value_b(compare_value_a), .count_load(1'b0), .count_wdata(8'h00),
    .reg_addr(reg_addr), .reg_io_space(reg_io_space), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .port_data_a(port_data_a), .port_dir_a(port_dir_a), .port_data_b(port_data_b),
    .port_dir_b(port_dir_b), .wave_out_a(wave_out_a), .wave_out_b(wave_out_b),
    .pin_a_out(pin_a_out), .pin_a_oe(pin_a_oe), .pin_b_out(pin_b_out), .pin_b_oe(pin_b_oe),
    .count_value(count_value),
    .overflow_clear(overflow_clear), .overflow_flag(overflow_flag));
  tpw_pin_load load_u (.core_clk(core_clk), .pin_out(pin_a_out), .pin_oe(pin_a_oe),
    .pin_level(pin_level));
  // ==========================================
  // reporting
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // hang guard: a stuck wait ends the run as a mismatch
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == CEIL) begin
      errors++;
      final_report();
    end
  end
  // ==========================================
  // register access, one strobe cycle each
  task automatic wr(input logic [7:0] a, input logic io, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_io_space <= io;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic io, output logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_io_space <= io;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // restart, configure, settle, then tally high cycles and pin disagreements
  task automatic run_case(input logic [7:0] ctrl, input logic b2, input logic [7:0] ocr,
      input int win, output logic [15:0] hi, output logic [15:0] bad);
    @(posedge core_clk);
    rst <= 1'b1;
    waveform_mode_bit2 <= b2;
    compare_value_a <= ocr;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    wr(8'h44, 1'b0, ctrl);
    repeat (1100) @(posedge core_clk);
    hi = 16'h0000;
    bad = 16'h0000;
    repeat (win) begin
      @(posedge core_clk);
      #1;
      hi = hi + {15'h0000, wave_out_a};
      bad = bad + {15'h0000, pin_level !== wave_out_a};
    end
  endtask
  // ==========================================
  // scenarios
  task automatic t_regs();
    logic [7:0] d;
    rd(8'h44, 1'b0, d);
    check("ctrl reset", {8'h00, d}, 16'h0000);
    wr(8'h44, 1'b0, 8'hFF);
    rd(8'h24, 1'b1, d);
    check("ctrl io read", {8'h00, d}, 16'h00F3);
    rd(8'h45, 1'b0, d);
    check("unmapped read", {8'h00, d}, 16'h0000);
    // data-space write then io-space read on the very next edge
    @(posedge core_clk);
    reg_addr <= 8'h44;
    reg_io_space <= 1'b0;
    reg_wdata <= 8'hA5;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_addr <= 8'h24;
    reg_io_space <= 1'b1;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 check("write then read", {8'h00, reg_rdata}, 16'h00A1);
    wr(8'h24, 1'b1, 8'h00);
    rd(8'h44, 1'b0, d);
    check("ctrl io write", {8'h00, d}, 16'h0000);
    $display("test regs done");
  endtask
  task automatic t_phase();
    logic [15:0] hi, bad;
    logic [7:0] ocr [3] = '{8'h00, 8'h80, 8'hFF};
    int e [3] = '{0, 256, 510};
    for (int i = 0; i < 3; i++) begin
      run_case(8'h81, 1'b0, ocr[i], 510, hi, bad);
      check("pc noninv high", hi, e[i][15:0]);
      run_case(8'hC1, 1'b0, ocr[i], 510, hi, bad);
      check("pc inv high", hi, 16'(510 - e[i]));
      check("pin follows wave", bad, 16'h0000);
    end
    $display("test phase pwm done");
  endtask
  task automatic t_period(input logic b2, input logic [7:0] top, input int per);
    logic [15:0] hi, bad;
    int n, tops;
    run_case(8'h81, b2, top, 1, hi, bad);
    n = 0;
    while (count_value !== 8'h00 && n < 600) begin
      @(posedge core_clk);
      #1 n++;
    end
    check("flag at bottom", {15'h0000, overflow_flag}, 16'h0001);
    @(posedge core_clk);
    overflow_clear <= 1'b1;
    @(posedge core_clk);
    overflow_clear <= 1'b0;
    #1 check("flag cleared", {15'h0000, overflow_flag}, 16'h0000);
    n = 2;
    tops = 0;
    while (count_value !== 8'h00 && n < 600) begin
      @(posedge core_clk);
      #1 n++;
      tops += (count_value === top);
    end
    check("period", 16'(n), 16'(per));
    check("cycles at top", 16'(tops), 16'h0001);
    $display("test period done");
  endtask
  task automatic t_other();
    logic [15:0] hi, bad;
    int e [3] = '{200, 0, 400};
    for (int c = 1; c < 4; c++) begin
      run_case({c[1:0], 6'h02}, 1'b0, 8'h03, 400, hi, bad);
      check("ctc high", hi, e[c - 1][15:0]);
    end
    run_case(8'h83, 1'b0, 8'h40, 256, hi, bad);
    check("fast noninv high", hi, 16'd65);
    run_case(8'hC3, 1'b0, 8'h40, 256, hi, bad);
    check("fast inv high", hi, 16'd191);
    run_case(8'h83, 1'b1, 8'h40, 130, hi, bad);
    check("fast top high", hi, 16'd130);
    run_case(8'h81, 1'b1, 8'h40, 128, hi, bad);
    check("pc top high", hi, 16'd128);
    run_case(8'h51, 1'b1, 8'h40, 256, hi, bad);
    check("pc toggle high", hi, 16'd128);
    check("b no toggle", {13'h0000, wave_out_b, pin_b_out, pin_b_oe}, 16'h0003);
    $display("test other modes done");
  endtask
  task automatic t_pin();
    logic [15:0] hi, bad;
    run_case(8'h41, 1'b0, 8'h40, 1, hi, bad);
    @(posedge core_clk);
    port_data_a <= 1'b1;
    @(posedge core_clk);
    #1 check("toggle off pin", {15'h0000, pin_a_out}, 16'h0001);
    @(posedge core_clk);
    port_dir_a <= 1'b0;
    @(posedge core_clk);
    #1 check("driver off", {15'h0000, pin_a_oe}, 16'h0000);
    @(posedge core_clk);
    port_dir_a <= 1'b1;
    $display("test pin done");
  endtask
  // ==========================================
  // main sequence
  initial begin
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    t_regs();
    t_phase();
    t_period(1'b0, 8'hFF, 510);
    t_period(1'b1, 8'h40, 128);
    t_other();
    t_pin();
    final_report();
  end
endmodule // timer8_phase_correct_pwm_out_bench
`default_nettype wire
